// >>> inc/port_mux_cfg.svh
// Purpose: constants of the port pin state, drive enable and alt mux
// Assumes: byte-wide register port from the internal processor
// Notes:   addresses are 16-bit register addresses
//
// Overview of operation
// - Pin-state registers return live pin levels in any pin mode.
// - Five read/write drive-enable registers, one bit per pin, reset 0.
// - Ports A to C pick each pin's alternate use by a select bit.
// - Ports D and E switch all eight pins at once in modes 10-11 with config bit 2 set.
// - Port A pins 0-2: engine state on config bit 3, else timers, strobe.
// - Port A pins 3, 6, 7 drive chip select and receive echoes.
// - Port A pins 4, 5: strobes, or ready and slave strobe inputs by secondary select.
// - Port B pins 0-3 carry external, engine or FIFO data in modes 01-11.
// - Without alternate use, enabled pins drive latch, others float.
// - Alternate use cuts latch and buffer; drive enable then ignored.
`ifndef PORT_MUX_CFG_SVH
`define PORT_MUX_CFG_SVH

`define ADDR_PORT_A_PIN_LEVELS      16'h7F99
`define ADDR_PORT_B_PIN_LEVELS      16'h7F9A
`define ADDR_PORT_C_PIN_LEVELS      16'h7F9B
`define ADDR_PORT_D_PIN_LEVELS      16'h7842
`define ADDR_PORT_E_PIN_LEVELS      16'h7846
`define ADDR_PORT_A_DRIVE_ENABLE    16'h7F9C
`define ADDR_PORT_B_DRIVE_ENABLE    16'h7F9D
`define ADDR_PORT_C_DRIVE_ENABLE    16'h7F9E
`define ADDR_PORT_D_DRIVE_ENABLE    16'h7843
`define ADDR_PORT_E_DRIVE_ENABLE    16'h7847
`define ADDR_PORT_A_ALT_SELECT      16'h7F93
`define ADDR_PORT_B_ALT_SELECT      16'h7F94
`define ADDR_PORT_C_ALT_SELECT      16'h7F95
`define ADDR_PORT_A_SECONDARY       16'h7F91
`define ADDR_INTERFACE_CONFIG       16'h784A

`define DRIVE_ENABLE_RESET          8'h00
`define ALT_SELECT_RESET            8'h00
`define INTERFACE_CONFIG_RESET      8'h00
`define READ_IDLE                   8'h00
`define PIN_RESET                   8'h00

`define IFCFG_MODE_MSB              1
`define IFCFG_MODE_LSB              0
`define IFCFG_GROUP_BIT             2
`define IFCFG_ENGINE_STATE_BIT      3

`endif

// >>> inc/port_mux_pkg.sv
// Purpose: types shared by the port pin mux files
// Assumes: five 8-bit ports
// Notes:   port_set_t holds one byte per port
package port_mux_pkg;

    typedef enum logic [1:0]
    {
        MODE_PORTS   = 2'b00,
        MODE_EXT_BUS = 2'b01,
        MODE_ENGINE  = 2'b10,
        MODE_FIFO    = 2'b11
    } if_mode_t;

    typedef struct packed
    {
        logic [7:0] e;
        logic [7:0] d;
        logic [7:0] c;
        logic [7:0] b;
        logic [7:0] a;
    } port_set_t;

    typedef struct packed
    {
        logic [2:0] engine_state_out;
        logic       timer0_toggle_out;
        logic       timer1_toggle_out;
        logic       ext_oe_strobe;
        logic       ext_chip_select;
        logic       serial0_receive_echo;
        logic       serial1_receive_echo;
        logic       write_strobe_out;
        logic       read_strobe_out;
        logic       serial1_transmit;
        logic [3:0] ext_bus_out;
        logic [3:0] ext_bus_oe;
        logic [3:0] engine_bus_out;
        logic [3:0] engine_bus_oe;
        logic [3:0] fifo_bus_out;
        logic [3:0] fifo_bus_oe;
        logic [7:0] port_d_alt_out;
        logic [7:0] port_d_alt_oe;
        logic [7:0] port_e_alt_out;
        logic [7:0] port_e_alt_oe;
    } alt_source_t;

    typedef struct packed
    {
        logic       ready_input_4;
        logic       ready_input_5;
        logic       slave_write_strobe;
        logic       slave_read_strobe;
        logic       timer2_count_input;
        logic       timer2_capture_input;
        logic       serial1_receive;
        logic [3:0] bus_data_in;
    } alt_sink_t;

    typedef struct packed
    {
        port_set_t  drive_enable;
        logic [7:0] port_a_alt_select;
        logic [7:0] port_b_alt_select;
        logic [7:0] port_c_alt_select;
        logic [7:0] port_a_secondary_select;
        logic [7:0] interface_configuration;
    } mux_config_t;

endpackage : port_mux_pkg

// >>> rtl/pin_sync.sv
// Purpose: two-stage synchronizer for pin levels
// Assumes: pins may change at any time
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
`include "port_mux_cfg.svh"
module pin_sync #(
    parameter int WIDTH = 40
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Levels
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb
    begin
        next_meta = d_in;
        next_q    = meta;
        if (rst_in)
        begin
            next_meta = '0;
            next_q    = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        meta  <= next_meta;
        q_out <= next_q;
    end
endmodule : pin_sync

// >>> rtl/port_alt_route.sv
// Purpose: per-pin choice between latch drive and alternate uses
// Assumes: configuration and sources are synchronous to the clock
// Notes:   purely combinational; the top registers the result
`timescale 1ns/100ps
`include "port_mux_cfg.svh"
module port_alt_route (
    // Configuration and sources
    input  port_mux_pkg::mux_config_t cfg_in,
    input  port_mux_pkg::port_set_t   latch_in,
    input  port_mux_pkg::alt_source_t src_in,
    // Pin drive
    output port_mux_pkg::port_set_t   pin_out,
    output port_mux_pkg::port_set_t   pin_oe_out
);
    import port_mux_pkg::*;

    if_mode_t   mode;
    logic [7:0] a_val;
    logic [7:0] a_drv;
    logic [7:0] ifcfg;

    always_comb
    begin
        ifcfg = cfg_in.interface_configuration;
        mode  = if_mode_t'(ifcfg[`IFCFG_MODE_MSB:`IFCFG_MODE_LSB]);
        // General I/O: latch drives where enabled and not alternate
        pin_out       = latch_in;
        pin_oe_out.a  = cfg_in.drive_enable.a & ~cfg_in.port_a_alt_select;
        pin_oe_out.b  = cfg_in.drive_enable.b & ~cfg_in.port_b_alt_select;
        pin_oe_out.c  = cfg_in.drive_enable.c & ~cfg_in.port_c_alt_select;
        pin_oe_out.d  = cfg_in.drive_enable.d;
        pin_oe_out.e  = cfg_in.drive_enable.e;
        // Port A alternate outputs
        a_val = {src_in.serial1_receive_echo, src_in.serial0_receive_echo,
                 src_in.read_strobe_out, src_in.write_strobe_out,
                 src_in.ext_chip_select, src_in.ext_oe_strobe,
                 src_in.timer1_toggle_out, src_in.timer0_toggle_out};
        a_drv = {2'b11, ~cfg_in.port_a_secondary_select[5:4], 4'hF};
        for (int i = 0; i < 8; i++)
        begin
            if (cfg_in.port_a_alt_select[i])
            begin
                pin_out.a[i]    = a_val[i];
                pin_oe_out.a[i] = a_drv[i];
            end
        end
        if (ifcfg[`IFCFG_ENGINE_STATE_BIT])
        begin
            pin_out.a[2:0]    = src_in.engine_state_out;
            pin_oe_out.a[2:0] = 3'h7;
        end
        // Port B low nibble
        case (mode)
            MODE_PORTS:
            begin
                if (cfg_in.port_b_alt_select[3])
                begin
                    pin_out.b[3]    = src_in.serial1_transmit;
                    pin_oe_out.b[3] = 1'b1;
                end
            end
            MODE_EXT_BUS:
            begin
                pin_out.b[3:0]    = src_in.ext_bus_out;
                pin_oe_out.b[3:0] = src_in.ext_bus_oe;
            end
            MODE_ENGINE:
            begin
                pin_out.b[3:0]    = src_in.engine_bus_out;
                pin_oe_out.b[3:0] = src_in.engine_bus_oe;
            end
            MODE_FIFO:
            begin
                pin_out.b[3:0]    = src_in.fifo_bus_out;
                pin_oe_out.b[3:0] = src_in.fifo_bus_oe;
            end
            default:
            begin
                pin_oe_out.b[3:0] = 4'h0;
            end
        endcase
        // Ports D and E switch as whole bytes
        if (mode[1] && ifcfg[`IFCFG_GROUP_BIT])
        begin
            pin_out.d    = src_in.port_d_alt_out;
            pin_oe_out.d = src_in.port_d_alt_oe;
            pin_out.e    = src_in.port_e_alt_out;
            pin_oe_out.e = src_in.port_e_alt_oe;
        end
    end
endmodule : port_alt_route

// >>> rtl/port_pin_state_oe_and_alt_mux.sv
// Purpose: pin state, drive enable and alternate routing of five ports
// Assumes: single-cycle register strobes from the internal processor
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/100ps
`include "port_mux_cfg.svh"
module port_pin_state_oe_and_alt_mux (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    // Register port
    input  wire logic [15:0]          reg_addr_in,
    input  wire logic                 reg_write_in,
    input  wire logic                 reg_read_in,
    input  wire logic [7:0]           reg_wdata_in,
    output logic      [7:0]           reg_rdata_out,
    // Core side
    input  port_mux_pkg::port_set_t   output_latch_in,
    input  port_mux_pkg::alt_source_t alt_source_in,
    output port_mux_pkg::alt_sink_t   alt_sink_out,
    // Pins
    input  port_mux_pkg::port_set_t   pin_in,
    output port_mux_pkg::port_set_t   pin_out,
    output port_mux_pkg::port_set_t   pin_oe_out
);
    import port_mux_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    mux_config_t cfg;
    mux_config_t next_cfg;
    port_set_t   levels;
    port_set_t   route_out;
    port_set_t   route_oe;
    port_set_t   next_pin_out;
    port_set_t   next_pin_oe;
    alt_sink_t   next_sink;
    logic [7:0]  next_rdata;
    if_mode_t    mode;

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    function automatic logic [7:0] read_mux(
        input logic [15:0] addr,
        input mux_config_t c,
        input port_set_t   lv
    );
        logic [7:0] r;
        r = `READ_IDLE;
        case (addr)
            `ADDR_PORT_A_PIN_LEVELS:   r = lv.a;
            `ADDR_PORT_B_PIN_LEVELS:   r = lv.b;
            `ADDR_PORT_C_PIN_LEVELS:   r = lv.c;
            `ADDR_PORT_D_PIN_LEVELS:   r = lv.d;
            `ADDR_PORT_E_PIN_LEVELS:   r = lv.e;
            `ADDR_PORT_A_DRIVE_ENABLE: r = c.drive_enable.a;
            `ADDR_PORT_B_DRIVE_ENABLE: r = c.drive_enable.b;
            `ADDR_PORT_C_DRIVE_ENABLE: r = c.drive_enable.c;
            `ADDR_PORT_D_DRIVE_ENABLE: r = c.drive_enable.d;
            `ADDR_PORT_E_DRIVE_ENABLE: r = c.drive_enable.e;
            `ADDR_PORT_A_ALT_SELECT:   r = c.port_a_alt_select;
            `ADDR_PORT_B_ALT_SELECT:   r = c.port_b_alt_select;
            `ADDR_PORT_C_ALT_SELECT:   r = c.port_c_alt_select;
            `ADDR_PORT_A_SECONDARY:    r = c.port_a_secondary_select;
            `ADDR_INTERFACE_CONFIG:    r = c.interface_configuration;
            default:                   r = `READ_IDLE;
        endcase
        return r;
    endfunction : read_mux

    // ------------------------------------------------------------
    // Pin synchronizer
    // ------------------------------------------------------------
    pin_sync #(
        .WIDTH ($bits(port_set_t))
    ) u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   (pin_in),
        .q_out  (levels)
    );

    // ------------------------------------------------------------
    // Alternate routing
    // ------------------------------------------------------------
    port_alt_route u_route (
        .cfg_in     (cfg),
        .latch_in   (output_latch_in),
        .src_in     (alt_source_in),
        .pin_out    (route_out),
        .pin_oe_out (route_oe)
    );

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_comb
    begin
        next_cfg = cfg;
        if (reg_write_in)
        begin
            case (reg_addr_in)
                `ADDR_PORT_A_DRIVE_ENABLE: next_cfg.drive_enable.a = reg_wdata_in;
                `ADDR_PORT_B_DRIVE_ENABLE: next_cfg.drive_enable.b = reg_wdata_in;
                `ADDR_PORT_C_DRIVE_ENABLE: next_cfg.drive_enable.c = reg_wdata_in;
                `ADDR_PORT_D_DRIVE_ENABLE: next_cfg.drive_enable.d = reg_wdata_in;
                `ADDR_PORT_E_DRIVE_ENABLE: next_cfg.drive_enable.e = reg_wdata_in;
                `ADDR_PORT_A_ALT_SELECT:   next_cfg.port_a_alt_select = reg_wdata_in;
                `ADDR_PORT_B_ALT_SELECT:   next_cfg.port_b_alt_select = reg_wdata_in;
                `ADDR_PORT_C_ALT_SELECT:   next_cfg.port_c_alt_select = reg_wdata_in;
                `ADDR_PORT_A_SECONDARY:
                    next_cfg.port_a_secondary_select = reg_wdata_in;
                `ADDR_INTERFACE_CONFIG:
                    next_cfg.interface_configuration = reg_wdata_in;
                default:
                    next_cfg = cfg;
            endcase
        end
        if (rst_in)
        begin
            next_cfg.drive_enable            = {5{`DRIVE_ENABLE_RESET}};
            next_cfg.port_a_alt_select       = `ALT_SELECT_RESET;
            next_cfg.port_b_alt_select       = `ALT_SELECT_RESET;
            next_cfg.port_c_alt_select       = `ALT_SELECT_RESET;
            next_cfg.port_a_secondary_select = `ALT_SELECT_RESET;
            next_cfg.interface_configuration = `INTERFACE_CONFIG_RESET;
        end
    end

    always_ff @(posedge clk_in)
    begin
        cfg <= next_cfg;
    end

    // ------------------------------------------------------------
    // Pin drive, alternate inputs and read data
    // ------------------------------------------------------------
    always_comb
    begin
        next_pin_out = route_out;
        next_pin_oe  = route_oe;
        // Alternate inputs always follow the pin
        next_sink.ready_input_4        = levels.a[4];
        next_sink.ready_input_5        = levels.a[5];
        next_sink.slave_write_strobe   = levels.a[4];
        next_sink.slave_read_strobe    = levels.a[5];
        next_sink.timer2_count_input   = levels.b[0];
        next_sink.timer2_capture_input = levels.b[1];
        next_sink.serial1_receive      = levels.b[2];
        next_sink.bus_data_in          = levels.b[3:0];
        next_rdata = `READ_IDLE;
        if (reg_read_in)
        begin
            next_rdata = read_mux(reg_addr_in, cfg, levels);
        end
        if (rst_in)
        begin
            next_pin_out = {5{`PIN_RESET}};
            next_pin_oe  = {5{`DRIVE_ENABLE_RESET}};
            next_sink    = '0;
            next_rdata   = `READ_IDLE;
        end
    end

    always_ff @(posedge clk_in)
    begin
        pin_out       <= next_pin_out;
        pin_oe_out    <= next_pin_oe;
        alt_sink_out  <= next_sink;
        reg_rdata_out <= next_rdata;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    assign mode = if_mode_t'(cfg.interface_configuration
                             [`IFCFG_MODE_MSB:`IFCFG_MODE_LSB]);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_reset_all_inputs: assert property (
        $fell(rst_in) |-> (pin_oe_out == '0) && (cfg.drive_enable == '0))
        else $error("pins not all inputs after reset");

    a_pin_level_read: assert property (
        reg_read_in && reg_addr_in == `ADDR_PORT_D_PIN_LEVELS
        && !$past(rst_in, 3)
        |=> reg_rdata_out == $past(pin_in.d, 3))
        else $error("port D level read not three cycles behind pin");

    a_sync_two_stage: assert property (
        !$past(rst_in, 2) |-> levels == $past(pin_in, 2))
        else $error("pin synchronizer depth wrong");

    a_drive_enable_rw: assert property (
        reg_read_in && reg_addr_in == `ADDR_PORT_B_DRIVE_ENABLE
        |=> reg_rdata_out == $past(cfg.drive_enable.b))
        else $error("drive enable read back differs");

    a_gpio_drive: assert property (
        !cfg.port_a_alt_select[6]
        |=> pin_oe_out.a[6] == $past(cfg.drive_enable.a[6])
            && pin_out.a[6] == $past(output_latch_in.a[6]))
        else $error("general pin drive wrong");

    a_alt_ignores_oe: assert property (
        cfg.port_a_alt_select[3] && !cfg.drive_enable.a[3]
        |=> pin_oe_out.a[3] && pin_out.a[3] == $past(alt_source_in.ext_chip_select))
        else $error("chip select not driven on alternate pin");

    a_echo_route: assert property (
        cfg.port_a_alt_select[7]
        |=> pin_out.a[7] == $past(alt_source_in.serial1_receive_echo))
        else $error("serial echo not routed");

    a_engine_state: assert property (
        cfg.interface_configuration[`IFCFG_ENGINE_STATE_BIT]
        |=> pin_oe_out.a[2:0] == 3'h7
            && pin_out.a[2:0] == $past(alt_source_in.engine_state_out))
        else $error("engine state not on port A");

    a_timer_route: assert property (
        !cfg.interface_configuration[`IFCFG_ENGINE_STATE_BIT]
        && cfg.port_a_alt_select[0]
        |=> pin_out.a[0] == $past(alt_source_in.timer0_toggle_out))
        else $error("timer 0 output not routed");

    a_strobe_secondary: assert property (
        cfg.port_a_alt_select[4]
        |=> pin_oe_out.a[4] == !$past(cfg.port_a_secondary_select[4]))
        else $error("strobe pin drive wrong");

    a_serial_transmit: assert property (
        mode == MODE_PORTS && cfg.port_b_alt_select[3]
        |=> pin_oe_out.b[3] && pin_out.b[3] == $past(alt_source_in.serial1_transmit))
        else $error("serial transmit not routed");

    a_port_b_bus: assert property (
        mode == MODE_ENGINE
        |=> pin_out.b[3:0] == $past(alt_source_in.engine_bus_out)
            && pin_oe_out.b[3:0] == $past(alt_source_in.engine_bus_oe))
        else $error("engine data bus not on port B");

    a_group_switch: assert property (
        mode[1] && cfg.interface_configuration[`IFCFG_GROUP_BIT]
        |=> pin_oe_out.e == $past(alt_source_in.port_e_alt_oe))
        else $error("port E group switch wrong");

    c_oe_write: cover property (
        reg_write_in && reg_addr_in == `ADDR_PORT_A_DRIVE_ENABLE);
    c_engine_mode: cover property (mode == MODE_ENGINE);
    c_ext_bus_mode: cover property (mode == MODE_EXT_BUS);
    c_level_read: cover property (
        reg_read_in && reg_addr_in == `ADDR_PORT_E_PIN_LEVELS);
endmodule : port_pin_state_oe_and_alt_mux

// >>> verification/pin_partner_model.sv
// Purpose: board circuitry on the forty port pins
// Assumes: the board drives every pin the device leaves free
// Notes:   a driven pin reads back the device's own level
`timescale 1ns/100ps
module pin_partner_model (
    // Device side
    input  port_mux_pkg::port_set_t pin_drive_in,
    input  port_mux_pkg::port_set_t pin_enable_in,
    // Board side
    input  port_mux_pkg::port_set_t board_level_in,
    output port_mux_pkg::port_set_t pin_level_out
);
    import port_mux_pkg::*;
    // Wire level from both drivers
    assign pin_level_out = (pin_drive_in & pin_enable_in)
                         | (board_level_in & ~pin_enable_in);
endmodule : pin_partner_model

// >>> verification/port_pin_state_oe_and_alt_mux_bench.sv
// Purpose: random and corner tests of the port pin mux
// Assumes: board model drives all pins left free
// Notes:   stimulus changes on the falling edge
`timescale 1ns/100ps
`include "port_mux_cfg.svh"
module port_pin_state_oe_and_alt_mux_bench;
    import port_mux_pkg::*;
    logic        clk_in;
    logic        rst_in;
    logic [15:0] adr;
    logic        wr_s;
    logic        rd_s;
    logic [7:0]  wd;
    logic [7:0]  rdat;
    logic [39:0] latch;
    alt_source_t src;
    alt_sink_t   sink;
    logic [39:0] board;
    logic [39:0] lvl;
    logic [39:0] drv;
    logic [39:0] en;
    logic [15:0] seed;
    logic [7:0]  v;
    logic [7:0]  r;
    logic [7:0]  q;
    logic [7:0]  oe_val [5];
    logic [15:0] oe_adr [5];
    int          fail_count;
    int          checked;

    port_pin_state_oe_and_alt_mux i_port_pin_state_oe_and_alt_mux (
        .clk_in          (clk_in),
        .rst_in          (rst_in),
        .reg_addr_in     (adr),
        .reg_write_in    (wr_s),
        .reg_read_in     (rd_s),
        .reg_wdata_in    (wd),
        .reg_rdata_out   (rdat),
        .output_latch_in (latch),
        .alt_source_in   (src),
        .alt_sink_out    (sink),
        .pin_in          (lvl),
        .pin_out         (drv),
        .pin_oe_out      (en)
    );
    pin_partner_model i_pin_partner_model (
        .pin_drive_in   (drv),
        .pin_enable_in  (en),
        .board_level_in (board),
        .pin_level_out  (lvl)
    );

    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] wire_lvl(logic [7:0] o, logic [7:0] e,
                                            logic [7:0] b);
        return (o & e) | (b & ~e);
    endfunction : wire_lvl
    task automatic shuffle();
        logic [71:0] t;
        t = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        src = t[67:0];
        latch = {rnd(), rnd(), rnd(), rnd(), rnd()};
        board = {rnd(), rnd(), rnd(), rnd(), rnd()};
    endtask : shuffle
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wait_n
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        adr = a;
        wd = d;
        wr_s = 1'b1;
        wait_n(1);
        wr_s = 1'b0;
        wait_n(1);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        adr = a;
        rd_s = 1'b1;
        wait_n(1);
        d = rdat;
        rd_s = 1'b0;
        wait_n(1);
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string w);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, w, got, exp);
        end
    endtask : chk
    task automatic chk_port(input int p, input logic [7:0] eo,
                            input logic [7:0] ee, input string w);
        chk(en[p*8+:8], ee, w);
        chk(drv[p*8+:8] & ee, eo & ee, w);
    endtask : chk_port
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        wait_n(10000);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

    // --------------------
    // Tests
    // --------------------
    initial
    begin
        seed = 16'h24A3;
        fail_count = 0;
        checked = 0;
        rst_in = 1'b1;
        adr = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        wd = 8'h00;
        latch = '0;
        src = '0;
        board = '0;
        oe_adr = '{`ADDR_PORT_A_DRIVE_ENABLE, `ADDR_PORT_B_DRIVE_ENABLE,
                   `ADDR_PORT_C_DRIVE_ENABLE, `ADDR_PORT_D_DRIVE_ENABLE,
                   `ADDR_PORT_E_DRIVE_ENABLE};
        wait_n(20);
        rst_in = 1'b0;
        for (int p = 0; p < 5; p++)
        begin
            rd(oe_adr[p], v);
            chk(v, 8'h00, "enable reset");
            chk(en[p*8+:8], 8'h00, "pins input after reset");
        end
        rd(16'h1234, v);
        chk(v, 8'h00, "unmapped read");
        $display("test reset done");
        for (int k = 0; k < 6; k++)
        begin
            shuffle();
            for (int p = 0; p < 5; p++)
            begin
                oe_val[p] = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : rnd();
                wr(oe_adr[p], oe_val[p]);
            end
            for (int p = 0; p < 5; p++)
            begin
                rd(oe_adr[p], v);
                chk(v, oe_val[p], "enable readback");
                chk_port(p, latch[p*8+:8], oe_val[p], "gpio drive");
            end
        end
        $display("test gpio done");
        for (int k = 0; k < 6; k++)
        begin
            r = wire_lvl(latch[(3+k%2)*8+:8], oe_val[3+k%2],
                         board[(3+k%2)*8+:8]);
            board[(3+k%2)*8+:8] = rnd();
            rd(k[0] ? `ADDR_PORT_E_PIN_LEVELS : `ADDR_PORT_D_PIN_LEVELS, v);
            chk(v, r, "level before sync");
            wait_n(1);
            rd(k[0] ? `ADDR_PORT_E_PIN_LEVELS : `ADDR_PORT_D_PIN_LEVELS, v);
            r = wire_lvl(latch[(3+k%2)*8+:8], oe_val[3+k%2],
                         board[(3+k%2)*8+:8]);
            chk(v, r, "live level");
        end
        $display("test levels done");
        wr(`ADDR_PORT_A_ALT_SELECT, 8'hFF);
        for (int k = 0; k < 4; k++)
        begin
            shuffle();
            wr(`ADDR_PORT_A_DRIVE_ENABLE, k[1] ? 8'h00 : 8'hFF);
            wr(`ADDR_INTERFACE_CONFIG, {4'h0, k[0], 3'h0});
            v = k[0] ? {5'h00, src.engine_state_out} : {5'h00,
                src.ext_oe_strobe, src.timer1_toggle_out,
                src.timer0_toggle_out};
            v |= {src.serial1_receive_echo, src.serial0_receive_echo,
                  src.read_strobe_out, src.write_strobe_out,
                  src.ext_chip_select, 3'h0};
            chk_port(0, v, 8'hFF, "port a alternate");
        end
        wr(`ADDR_PORT_A_SECONDARY, 8'h30);
        for (int m = 2; m < 4; m++)
        begin
            wr(`ADDR_INTERFACE_CONFIG, 8'(m));
            board[7:0] = rnd();
            wait_n(4);
            chk({4'h0, sink.ready_input_4, sink.ready_input_5,
                 sink.slave_write_strobe, sink.slave_read_strobe},
                {4'h0, board[4], board[5], board[4], board[5]},
                "ready and slave inputs");
            chk(en[7:0] & 8'h30, 8'h00, "pins 4 5 released");
        end
        $display("test port a done");
        wr(`ADDR_INTERFACE_CONFIG, 8'h00);
        wr(`ADDR_PORT_B_DRIVE_ENABLE, 8'hFF);
        wr(`ADDR_PORT_C_DRIVE_ENABLE, 8'hFF);
        for (int k = 0; k < 4; k++)
        begin
            shuffle();
            r = (k == 0) ? 8'h0F : rnd();
            wr(`ADDR_PORT_B_ALT_SELECT, r);
            wr(`ADDR_PORT_C_ALT_SELECT, ~r);
            v = {latch[15:12], r[3] ? src.serial1_transmit : latch[11],
                 latch[10:8]};
            chk_port(1, v, ~r | 8'h08, "port b select");
            chk_port(2, latch[23:16], r, "port c select");
            rd(`ADDR_PORT_B_ALT_SELECT, q);
            chk(q, r, "alt select readback");
            wait_n(4);
            v = wire_lvl(v, ~r | 8'h08, board[15:8]);
            chk({1'b0, sink.timer2_count_input, sink.timer2_capture_input,
                 sink.serial1_receive, sink.bus_data_in},
                {1'b0, v[0], v[1], v[2], v[3:0]}, "port b inputs");
        end
        wr(`ADDR_PORT_B_ALT_SELECT, 8'h00);
        for (int m = 1; m < 4; m++)
        begin
            shuffle();
            wr(`ADDR_INTERFACE_CONFIG, 8'(m));
            v = (m == 1) ? {src.ext_bus_oe, src.ext_bus_out}
              : (m == 2) ? {src.engine_bus_oe, src.engine_bus_out}
              : {src.fifo_bus_oe, src.fifo_bus_out};
            chk({4'h0, en[11:8]}, {4'h0, v[7:4]}, "bus enables");
            chk({4'h0, drv[11:8] & v[7:4]}, {4'h0, v[3:0] & v[7:4]},
                "bus data");
        end
        $display("test port b c done");
        wr(`ADDR_PORT_D_DRIVE_ENABLE, 8'hFF);
        wr(`ADDR_PORT_E_DRIVE_ENABLE, 8'hFF);
        for (int k = 0; k < 8; k++)
        begin
            shuffle();
            wr(`ADDR_INTERFACE_CONFIG, 8'(k));
            v = (k[2] & k[1]) ? src.port_d_alt_oe : 8'hFF;
            r = (k[2] & k[1]) ? src.port_d_alt_out : latch[31:24];
            chk_port(3, r, v, "port d group");
            chk_port(4, (k[2] & k[1]) ? src.port_e_alt_out : latch[39:32],
                     (k[2] & k[1]) ? src.port_e_alt_oe : 8'hFF,
                     "port e group");
            wait_n(2);
            rd(`ADDR_PORT_D_PIN_LEVELS, q);
            chk(q, wire_lvl(r, v, board[31:24]), "group level");
        end
        $display("test port d e done");
        end_of_test();
    end
endmodule : port_pin_state_oe_and_alt_mux_bench
